// >>> hw/dro_consts.svh
// Constants for the DS3 receive overhead strobe port
`ifndef DRO_CONSTS_SVH
`define DRO_CONSTS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
// Overhead bits carried per DS3 frame (strobe counts 0 to 55)
`define DRO_OH_BITS 56
// Strobe count that goes with the frame marker (X bit)
`define DRO_FIRST_COUNT 0
// Strobe count of the last overhead bit of a frame
`define DRO_LAST_COUNT 55

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// DS3 line rate in kHz, the rate of the receive output clock
`define DRO_DS3_RATE_KHZ 44736
// Receive output clock cycles per overhead bit period (one M-subframe
// block: one overhead bit and 84 payload bits)
`define DRO_BIT_CYCLES 85
// Cycle within a bit period on which the strobe is raised (the middle)
`define DRO_STROBE_POS (`DRO_BIT_CYCLES / 2)

`endif

// >>> hw/dro_pkg.sv
// Types for the DS3 receive overhead strobe port
package dro_pkg;

  // ----------------------------------------------------------------------
  // Serializer states
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    DRO_IDLE,
    DRO_SHIFT
  } dro_state_e;

endpackage

// >>> hw/dro_xfer_if.sv
// Frame word crossing from the core clock to the receive output clock
`timescale 1ns/1ps
`include "dro_consts.svh"

interface dro_xfer_if #(
  parameter int OH_BITS = `DRO_OH_BITS
);
  // Overhead word, held stable while a request is open
  logic [OH_BITS-1:0] word;
  // Request toggle, core clock domain
  logic req_tgl;
  // Acknowledge toggle, receive output clock domain
  logic ack_tgl;

  modport src (
    output word,
    output req_tgl,
    input ack_tgl
  );

  modport dst (
    input word,
    input req_tgl,
    output ack_tgl
  );
endinterface

// >>> hw/dro_capture.sv
// Core side capture of one frame's overhead word and toggle handshake
`timescale 1ns/1ps
`include "dro_consts.svh"

module dro_capture #(
  parameter int OH_BITS = `DRO_OH_BITS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Frame word from the receive framer core
  input wire logic i_load,
  input wire logic [OH_BITS-1:0] i_word,
  output logic o_ready,
  // Crossing toward the receive output clock
  dro_xfer_if.src xfer
);

  logic [OH_BITS-1:0] word_q;
  logic req_q;
  logic ack_meta_q;
  logic ack_sync_q;
  wire take = i_load && o_ready;

  // Free when the far side has acknowledged the last request
  assign o_ready = (req_q == ack_sync_q);
  assign xfer.word = word_q;
  assign xfer.req_tgl = req_q;

  // Acknowledge toggle synchroniser
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= xfer.ack_tgl;
      ack_sync_q <= ack_meta_q;
    end
  end

  // Word held until acknowledged, so the far side reads it settled
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      word_q <= '0;
      req_q <= 1'b0;
    end else if (take) begin
      word_q <= i_word;
      req_q <= ~req_q;
    end
  end

endmodule

// >>> hw/dro_top.sv
// DS3 receive overhead port using the output clock and a sample strobe
`timescale 1ns/1ps
`include "dro_consts.svh"

module dro_top #(
  parameter int OH_BITS = `DRO_OH_BITS,
  parameter int BIT_CYCLES = `DRO_BIT_CYCLES,
  parameter int STROBE_POS = `DRO_STROBE_POS
) (
  // Core clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Candidate sources of the receive output clock
  input wire logic i_recovered_line_clock,
  input wire logic i_local_transmit_input_clock,
  input wire logic i_loop_timing,
  // Frame word from the receive framer core (core clock)
  input wire logic i_oh_load,
  input wire logic [OH_BITS-1:0] i_oh_word,
  output logic o_oh_ready,
  // Overhead port toward the terminal equipment
  output logic o_receive_output_clock,
  output logic o_overhead_bit_out,
  output logic o_overhead_sample_strobe,
  output logic o_overhead_frame_marker
);

  // ----------------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------------
  localparam int CW = $clog2(BIT_CYCLES);
  localparam int IW = $clog2(OH_BITS);
  localparam logic [CW-1:0] CYC_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] CYC_STROBE = CW'(STROBE_POS);
  localparam logic [IW-1:0] IDX_FIRST = IW'(`DRO_FIRST_COUNT);
  localparam logic [IW-1:0] IDX_LAST = IW'(`DRO_LAST_COUNT);

  // ----------------------------------------------------------------------
  // Receive output clock selection
  // ----------------------------------------------------------------------
  // Timing mode is a static strap; changing it live can glitch the clock.
  // The chosen source is a DS3 clock at the line rate.
  wire rx_clk = i_loop_timing ? i_recovered_line_clock
                              : i_local_transmit_input_clock;
  assign o_receive_output_clock = rx_clk;

  // ----------------------------------------------------------------------
  // Core side capture
  // ----------------------------------------------------------------------
  dro_xfer_if #(.OH_BITS(OH_BITS)) xfer ();

  dro_capture #(
    .OH_BITS(OH_BITS)
  ) u_capture (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_load(i_oh_load),
    .i_word(i_oh_word),
    .o_ready(o_oh_ready),
    .xfer(xfer)
  );

  // ----------------------------------------------------------------------
  // Link side request detection
  // ----------------------------------------------------------------------
  logic req_meta_q;
  logic req_sync_q;
  logic ack_q;
  logic [OH_BITS-1:0] pend_q;
  logic pend_valid_q;

  // New word waiting when the synced request differs from our ack
  wire req_new = (req_sync_q != ack_q);

  // Request toggle synchroniser
  always_ff @(posedge rx_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= xfer.req_tgl;
      req_sync_q <= req_meta_q;
    end
  end

  assign xfer.ack_tgl = ack_q;

  // ----------------------------------------------------------------------
  // Serializer state
  // ----------------------------------------------------------------------
  dro_pkg::dro_state_e state_q;
  dro_pkg::dro_state_e state_d;
  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_d;
  logic [IW-1:0] idx_q;
  logic [IW-1:0] idx_d;
  logic [OH_BITS-1:0] shift_q;
  logic [OH_BITS-1:0] shift_d;
  logic bit_q;
  logic strobe_q;
  logic frame_q;

  // Boundary and frame end decode
  wire shifting = (state_q == dro_pkg::DRO_SHIFT);
  wire bit_end = shifting && (cyc_q == CYC_LAST);
  wire frame_end = bit_end && (idx_q == IDX_LAST);
  wire need_word = !shifting || frame_end;
  wire start = need_word && pend_valid_q;
  wire take_req = req_new && (!pend_valid_q || start);

  // Next state: idle until a word is pending, frames run back to back
  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    idx_d = idx_q;
    shift_d = shift_q;
    if (start) begin
      state_d = dro_pkg::DRO_SHIFT;
      cyc_d = '0;
      idx_d = IDX_FIRST;
      shift_d = pend_q;
    end else if (frame_end) begin
      state_d = dro_pkg::DRO_IDLE;
      cyc_d = '0;
    end else if (bit_end) begin
      cyc_d = '0;
      idx_d = idx_q + IW'(1);
      shift_d = {1'b0, shift_q[OH_BITS-1:1]};
    end else if (shifting) begin
      cyc_d = cyc_q + CW'(1);
    end
  end

  // Pending word slot, refilled while the current frame shifts
  always_ff @(posedge rx_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_q <= '0;
      pend_valid_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (take_req) begin
      pend_q <= xfer.word;
      pend_valid_q <= 1'b1;
      ack_q <= ~ack_q;
    end else if (start) begin
      pend_valid_q <= 1'b0;
    end
  end

  // Serializer registers
  always_ff @(posedge rx_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= dro_pkg::DRO_IDLE;
      cyc_q <= '0;
      idx_q <= '0;
      shift_q <= '0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      idx_q <= idx_d;
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------------------------------------
  // Port outputs
  // ----------------------------------------------------------------------
  // Bit and marker are loaded from the next state so they change only at
  // bit boundaries; word bit 0 is the X bit of strobe count 0.
  wire next_shift = (state_d == dro_pkg::DRO_SHIFT);
  wire next_first = next_shift && (idx_d == IDX_FIRST);
  wire next_strobe = next_shift && (cyc_d == CYC_STROBE);

  // Overhead data, marker and strobe registers
  always_ff @(posedge rx_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_q <= 1'b0;
      frame_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      bit_q <= next_shift ? shift_d[0] : 1'b0;
      frame_q <= next_first;
      strobe_q <= next_strobe;
    end
  end

  // The terminal samples these on falling edges while the strobe is high
  assign o_overhead_bit_out = bit_q;
  assign o_overhead_frame_marker = frame_q;
  assign o_overhead_sample_strobe = strobe_q;

endmodule

// >>> verif/dro_top_asserts.sv
// Checker for the overhead strobe port
`timescale 1ns/1ps
module dro_top_asserts #(
  parameter int OH_BITS = 56,
  parameter int BIT_CYCLES = 85,
  parameter int STROBE_POS = 42
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_recovered_line_clock,
  input wire logic i_local_transmit_input_clock,
  input wire logic i_loop_timing,
  input wire logic i_oh_load,
  input wire logic [OH_BITS-1:0] i_oh_word,
  input wire logic o_oh_ready,
  input wire logic o_receive_output_clock,
  input wire logic o_overhead_bit_out,
  input wire logic o_overhead_sample_strobe,
  input wire logic o_overhead_frame_marker
);
  localparam int BM1 = BIT_CYCLES - 1;
  localparam int CHG = BIT_CYCLES - STROBE_POS - 1;
  int gap_q;
  int cnt_q;
  logic seen_q;
  wire logic stb = o_overhead_sample_strobe;
  wire logic mrk = o_overhead_frame_marker;
  // Cycles since last strobe, strobes since marker
  always_ff @(posedge o_receive_output_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_q <= BIT_CYCLES;
      cnt_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= stb ? 0 : (gap_q < BIT_CYCLES ? gap_q + 1 : gap_q);
      if (stb) begin
        cnt_q <= mrk ? 0 : cnt_q + 1;
        seen_q <= seen_q | mrk;
      end
    end
  end
  property p_stb_pulse;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      stb |=> !stb;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse)
    else $error("strobe longer than one cycle");
  property p_stb_gap;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      stb && gap_q < BIT_CYCLES |-> gap_q == BM1;
  endproperty
  a_stb_gap: assert property (p_stb_gap)
    else $error("strobe spacing wrong");
  property p_mrk_stb;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      $rose(mrk) |-> ##STROBE_POS stb;
  endproperty
  a_mrk_stb: assert property (p_mrk_stb)
    else $error("no strobe in marker period");
  property p_mrk_len;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      $rose(mrk) |-> (mrk throughout (##BM1 1'b1)) ##1 !mrk;
  endproperty
  a_mrk_len: assert property (p_mrk_len)
    else $error("marker length wrong");
  property p_bit_stable;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      stb |-> $stable(o_overhead_bit_out) ##1 $stable(o_overhead_bit_out);
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("data moved near strobe");
  property p_bit_edge;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      $changed(o_overhead_bit_out) |-> gap_q == CHG || $rose(mrk);
  endproperty
  a_bit_edge: assert property (p_bit_edge)
    else $error("data changed inside a bit");
  property p_count;
    @(posedge o_receive_output_clock) disable iff (!i_nrst)
      stb && seen_q |-> mrk == (cnt_q == OH_BITS - 1);
  endproperty
  a_count: assert property (p_count)
    else $error("marker not every 56 strobes");
  property p_clk_sel;
    @(posedge i_clock) disable iff (!i_nrst)
      o_receive_output_clock == (i_loop_timing ? i_recovered_line_clock
        : i_local_transmit_input_clock);
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("output clock source wrong");
endmodule
bind dro_top dro_top_asserts #(.OH_BITS(OH_BITS), .BIT_CYCLES(BIT_CYCLES),
  .STROBE_POS(STROBE_POS)) u_chk (.*);

// >>> verif/dro_term_model.sv
// Terminal equipment model sampling the overhead port
`timescale 1ns/1ps
module dro_term_model (
  // Overhead port
  input wire logic i_clock,
  input wire logic i_bit,
  input wire logic i_strobe,
  input wire logic i_marker,
  // Captured frames
  output logic [55:0] o_word,
  output logic [7:0] o_frames
);
  logic [55:0] shift_q = 56'h0;
  logic [55:0] word_q = 56'h0;
  logic [7:0] frames_q = 8'h00;
  int cnt_q = 0;
  // Captured frame and frame count
  assign o_word = word_q;
  assign o_frames = frames_q;
  // Capture on falling edges while strobe is high
  always @(negedge i_clock) begin
    if (i_strobe === 1'b1) begin
      cnt_q = (i_marker === 1'b1) ? 0 : cnt_q + 1;
      shift_q[cnt_q % 56] = i_bit;
      if (cnt_q == 55) begin
        word_q = shift_q;
        frames_q = frames_q + 8'h01;
      end
    end
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the overhead strobe port
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic rec_clk = 1'b0;
  logic loc_clk = 1'b0;
  logic loop_sel = 1'b1;
  logic load = 1'b0;
  logic [55:0] word = 56'h0;
  logic ready, rxclk, ohbit, stb, mrk;
  logic [55:0] got;
  logic [7:0] frames;
  int num_errors = 0;
  int checks = 0;
  always #5 i_clock = ~i_clock;
  initial #2 forever #15 rec_clk = ~rec_clk;
  initial #7 forever #15 loc_clk = ~loc_clk;
  dro_top #(.OH_BITS(56), .BIT_CYCLES(6), .STROBE_POS(3)) uut (
    .i_clock(i_clock), .i_nrst(i_nrst),
    .i_recovered_line_clock(rec_clk),
    .i_local_transmit_input_clock(loc_clk),
    .i_loop_timing(loop_sel), .i_oh_load(load), .i_oh_word(word),
    .o_oh_ready(ready), .o_receive_output_clock(rxclk),
    .o_overhead_bit_out(ohbit), .o_overhead_sample_strobe(stb),
    .o_overhead_frame_marker(mrk));
  dro_term_model u_term (.i_clock(rxclk), .i_bit(ohbit), .i_strobe(stb),
    .i_marker(mrk), .o_word(got), .o_frames(frames));
  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [55:0] w);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 1200) begin
      @(negedge i_clock);
      n++;
    end
    if (ready !== 1'b1) begin
      num_errors++;
      summarize();
    end
    @(posedge i_clock);
    load <= 1'b1;
    word <= w;
    @(posedge i_clock);
    load <= 1'b0;
  endtask
  task automatic wait_frame(input logic [55:0] exp);
    int n;
    logic [7:0] f;
    n = 0;
    f = frames;
    while (frames === f && n < 1100) begin
      @(negedge i_clock);
      n++;
    end
    if (frames === f) begin
      num_errors++;
      summarize();
    end
    chk(got, exp);
  endtask
  task automatic t_single;
    send(56'hFF_FFFF_FFFF_FFFF);
    wait_frame(56'hFF_FFFF_FFFF_FFFF);
    repeat (40) @(negedge i_clock);
    chk({53'h0, ohbit, stb, mrk}, 56'h0);
    repeat (3) begin
      @(negedge i_clock);
      chk({55'h0, rxclk}, {55'h0, rec_clk});
    end
  endtask
  task automatic t_b2b;
    send(56'hA5_0F3C_96E1_7B2D);
    @(negedge i_clock);
    chk({55'h0, ready}, 56'h0);
    @(posedge i_clock);
    load <= 1'b1;
    word <= 56'h12_3456_789A_BCDE;
    @(posedge i_clock);
    load <= 1'b0;
    send(56'h5A_C3F0_691E_84D2);
    wait_frame(56'hA5_0F3C_96E1_7B2D);
    wait_frame(56'h5A_C3F0_691E_84D2);
  endtask
  task automatic t_local;
    repeat (40) @(posedge i_clock);
    loop_sel <= 1'b0;
    send(56'h80_0000_0000_0001);
    wait_frame(56'h80_0000_0000_0001);
    repeat (3) begin
      @(negedge i_clock);
      chk({55'h0, rxclk}, {55'h0, loc_clk});
    end
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_single();
    t_b2b();
    t_local();
    summarize();
  end
endmodule
